// >>> verilog/dicc_top.sv
// digital input conditioning, routing and capture, object dictionary access
`timescale 1ns/100ps
module dicc_top
  import dicc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  // physical inputs 1 to 16, bit 0 is input 1
  input wire logic [15:0] physIn,
  // encoder and supply signals usable as routing sources
  input wire logic encA,
  input wire logic encB,
  input wire logic encIndex,
  input wire logic usbPower,
  // high while inputs 1 and 2 serve as clock and direction
  input wire logic clkDirMode,
  // live positions for capture
  input wire logic [31:0] actualUserPos,
  input wire logic [31:0] sensorRawPos,
  // object dictionary access port
  input wire logic [15:0] objIndex,
  input wire logic [7:0] objSub,
  input wire logic objWrite,
  input wire logic objRead,
  input wire logic [31:0] objWrData,
  output logic [31:0] objRdData,
  output logic objRdValid,
  output logic objAccessErr,
  // conditioned results
  output logic [31:0] inputStatus,
  output logic negLimitActive,
  output logic posLimitActive,
  output logic homeActive,
  output logic [31:0] thresholdSel,
  output logic [31:0] diffSel,
  output logic captureEvent
);
  // settings registers
  logic [31:0] specialOn_q; // special function enables
  logic [31:0] polarity_q; // normally closed selection
  logic [31:0] overrideOn_q; // software forcing enables
  logic [31:0] overrideLvl_q; // forced levels
  logic [31:0] threshold_q; // 24 V threshold selection
  logic [31:0] diff_q; // differential selection
  logic [31:0] routingOn_q; // routing enable word
  logic [7:0] route_q [NUM_ROUTES]; // routing source per status bit
  // sampled and conditioned levels
  logic [15:0] rawSample_q; // sampled physical inputs
  logic [3:0] encSample_q; // sampled A, B, index, usb power
  logic [15:0] forced; // after override
  logic [15:0] polMask; // polarity bits that may act
  logic [15:0] logical; // after polarity
  logic [31:0] status_d; // status word before the flop
  logic [31:0] status_q;
  logic negLimit_q;
  logic posLimit_q;
  logic home_q;
  // access port state
  logic [31:0] rdData_d;
  logic [31:0] rdData_q;
  logic rdValid_q;
  logic err_q;
  logic hitCtrl; // access to input control group
  logic hitCap; // access to capture group
  logic hitRoute; // access to routing group
  logic subOk; // subindex exists in its group
  logic subWritable; // subindex accepts writes
  logic wrOk; // accepted write this cycle
  logic [5:0] routeSel; // routing entry addressed, 0 based
  logic [7:0] routeSubMinus; // subindex minus one
  // capture unit link
  dicc_cap_if capLink ();

  // routing source lookup, unknown codes give 0
  function automatic logic routeSource(input logic [7:0] code, input logic [15:0] lv,
      input logic [3:0] enc);
    logic [6:0] base;
    logic val;
    base = code[6:0];
    val = 1'b0;
    if (base == SRC_ZERO) begin
      val = code[SRC_INVERT_BIT];
    end else if (base <= 7'(NUM_INPUTS)) begin
      // physical input n, optionally inverted
      val = lv[4'(base - 7'h01)] ^ code[SRC_INVERT_BIT];
    end else if (base >= SRC_ENC_FIRST && base <= SRC_ENC_LAST) begin
      // encoder signals and usb power
      val = enc[2'(base - SRC_ENC_FIRST)] ^ code[SRC_INVERT_BIT];
    end
    return val;
  endfunction : routeSource

  // sample physical inputs every cycle
  // sampled levels, untouched
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rawSample_q <= 16'h0000;
      encSample_q <= 4'h0;
    end else begin
      rawSample_q <= physIn;
      encSample_q <= {usbPower, encIndex, encB, encA};
    end
  end

  // override replaces the sampled level bit by bit
  // override drops physical level
  assign forced = (rawSample_q & ~overrideOn_q[15:0]) | (overrideLvl_q[15:0] & overrideOn_q[15:0]);

  // clock and direction inputs never inverted
  // spare clock/direction inputs
  assign polMask = clkDirMode ? (polarity_q[15:0] & ~CLKDIR_MASK) : polarity_q[15:0];

  // normally closed inputs read inverted, bit 0 is input 1
  // polarity inversion
  assign logical = forced ^ polMask;

  // status word, direct or through routing
  // routing enable
  always_comb begin
    status_d = {16'h0000, logical};
    if (routingOn_q[0]) begin
      for (int n = 0; n < 32; n++) begin
        status_d[n] = routeSource(route_q[n], logical, encSample_q);
      end
    end
  end

  // status and special function flags
  // enable bit gates function
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_q <= WORD_RESET;
      negLimit_q <= 1'b0;
      posLimit_q <= 1'b0;
      home_q <= 1'b0;
    end else begin
      status_q <= status_d;
      negLimit_q <= specialOn_q[SF_NEG_LIMIT] & logical[SF_NEG_LIMIT];
      posLimit_q <= specialOn_q[SF_POS_LIMIT] & logical[SF_POS_LIMIT];
      home_q <= specialOn_q[SF_HOME] & logical[SF_HOME];
    end
  end

  // address decode
  assign hitCtrl = objIndex == IDX_INPUT_CTRL;
  assign hitCap = objIndex == IDX_CAPTURE;
  assign hitRoute = objIndex == IDX_ROUTING;
  assign routeSubMinus = objSub - 8'h01;
  assign routeSel = routeSubMinus[5:0];

  // which subindices exist and which take writes
  always_comb begin
    subOk = 1'b0;
    subWritable = 1'b0;
    if (hitCtrl) begin
      subOk = objSub <= INPUT_CTRL_ENTRIES;
      // unmodified word ignores writes but takes them without error
      subWritable = subOk && objSub != SUB_ENTRIES;
    end else if (hitCap) begin
      subOk = objSub <= CAPTURE_ENTRIES;
      subWritable = subOk && objSub != SUB_ENTRIES;
    end else if (hitRoute) begin
      subOk = objSub <= ROUTING_ENTRIES;
      subWritable = subOk && objSub != SUB_ENTRIES;
    end
  end

  assign wrOk = objWrite && subWritable;

  // input control settings
  // threshold bits stored
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      specialOn_q <= WORD_RESET;
      polarity_q <= WORD_RESET;
      overrideOn_q <= WORD_RESET;
      overrideLvl_q <= WORD_RESET;
      threshold_q <= WORD_RESET;
      diff_q <= WORD_RESET;
      routingOn_q <= WORD_RESET;
    end else if (wrOk && hitCtrl) begin
      unique case (objSub)
        SUB_SPECIAL_ON: specialOn_q <= objWrData;
        SUB_POLARITY: polarity_q <= objWrData;
        SUB_OVERRIDE_ON: overrideOn_q <= objWrData;
        SUB_OVERRIDE_LVL: overrideLvl_q <= objWrData;
        SUB_THRESHOLD: threshold_q <= objWrData;
        SUB_DIFF: diff_q <= objWrData;
        SUB_ROUTING_ON: routingOn_q <= objWrData;
        default: ; // unmodified word, writes dropped
      endcase
    end
  end

  // routing table
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int n = 0; n < NUM_ROUTES; n++) begin
        route_q[n] <= ROUTE_RESET;
      end
    end else if (wrOk && hitRoute) begin
      route_q[routeSel] <= objWrData[7:0];
    end
  end

  // capture unit hookup
  assign capLink.level = rawSample_q[0];
  assign capLink.wrCtrl = wrOk && hitCap && objSub == SUB_CAP_CTRL;
  assign capLink.wrCount = wrOk && hitCap && objSub == SUB_CAP_COUNT;
  assign capLink.wrUser = wrOk && hitCap && objSub == SUB_CAP_USER;
  assign capLink.wrSensor = wrOk && hitCap && objSub == SUB_CAP_SENSOR;
  assign capLink.wrData = objWrData;
  assign capLink.userPos = actualUserPos;
  assign capLink.sensorPos = sensorRawPos;

  dicc_capture uCapture (
    .clk(clk),
    .rst_b(rst_b),
    .capIf(capLink.cap)
  );

  // read data selection
  always_comb begin
    rdData_d = WORD_RESET;
    if (hitCtrl) begin
      unique case (objSub)
        SUB_ENTRIES: rdData_d = {24'h000000, INPUT_CTRL_ENTRIES};
        SUB_SPECIAL_ON: rdData_d = specialOn_q;
        SUB_POLARITY: rdData_d = polarity_q;
        SUB_OVERRIDE_ON: rdData_d = overrideOn_q;
        SUB_OVERRIDE_LVL: rdData_d = overrideLvl_q;
        SUB_UNMODIFIED: rdData_d = {16'h0000, rawSample_q};
        SUB_THRESHOLD: rdData_d = threshold_q;
        SUB_DIFF: rdData_d = diff_q;
        SUB_ROUTING_ON: rdData_d = routingOn_q;
        default: rdData_d = WORD_RESET; // missing subindex
      endcase
    end else if (hitCap) begin
      unique case (objSub)
        SUB_ENTRIES: rdData_d = {24'h000000, CAPTURE_ENTRIES};
        SUB_CAP_CTRL: rdData_d = capLink.ctrl;
        SUB_CAP_COUNT: rdData_d = capLink.count;
        SUB_CAP_USER: rdData_d = capLink.capUser;
        SUB_CAP_SENSOR: rdData_d = capLink.capSensor;
        default: rdData_d = WORD_RESET; // missing subindex
      endcase
    end else if (hitRoute) begin
      if (objSub == SUB_ENTRIES) begin
        rdData_d = {24'h000000, ROUTING_ENTRIES};
      end else if (subOk) begin
        rdData_d = {24'h000000, route_q[routeSel]};
      end
    end
  end

  // access answer one cycle after the request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData_q <= WORD_RESET;
      rdValid_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      rdValid_q <= objRead && subOk;
      rdData_q <= objRead ? rdData_d : rdData_q;
      // unknown object or write to a read-only entry
      err_q <= (objRead && !subOk) || (objWrite && !subWritable);
    end
  end

  // outputs, all from flops
  assign objRdData = rdData_q;
  assign objRdValid = rdValid_q;
  assign objAccessErr = err_q;
  assign inputStatus = status_q;
  assign negLimitActive = negLimit_q;
  assign posLimitActive = posLimit_q;
  assign homeActive = home_q;
  assign thresholdSel = threshold_q;
  assign diffSel = diff_q;
  assign captureEvent = capLink.capHit;
endmodule : dicc_top

// >>> inc/dicc_pkg.sv
// constants and types shared by the input conditioning and capture block
package dicc_pkg;
  // object indices of the three register groups
  localparam logic [15:0] IDX_INPUT_CTRL = 16'h3240;
  localparam logic [15:0] IDX_CAPTURE = 16'h3241;
  localparam logic [15:0] IDX_ROUTING = 16'h3242;
  // input control group subindices
  localparam logic [7:0] SUB_ENTRIES = 8'h00;
  localparam logic [7:0] SUB_SPECIAL_ON = 8'h01;
  localparam logic [7:0] SUB_POLARITY = 8'h02;
  localparam logic [7:0] SUB_OVERRIDE_ON = 8'h03;
  localparam logic [7:0] SUB_OVERRIDE_LVL = 8'h04;
  localparam logic [7:0] SUB_UNMODIFIED = 8'h05;
  localparam logic [7:0] SUB_THRESHOLD = 8'h06;
  localparam logic [7:0] SUB_DIFF = 8'h07;
  localparam logic [7:0] SUB_ROUTING_ON = 8'h08;
  // capture group subindices
  localparam logic [7:0] SUB_CAP_CTRL = 8'h01;
  localparam logic [7:0] SUB_CAP_COUNT = 8'h02;
  localparam logic [7:0] SUB_CAP_USER = 8'h03;
  localparam logic [7:0] SUB_CAP_SENSOR = 8'h04;
  // read-only entry counts
  localparam logic [7:0] INPUT_CTRL_ENTRIES = 8'h08;
  localparam logic [7:0] CAPTURE_ENTRIES = 8'h04;
  localparam logic [7:0] ROUTING_ENTRIES = 8'h24;
  // reset values
  localparam logic [31:0] WORD_RESET = 32'h00000000;
  localparam logic [7:0] ROUTE_RESET = 8'h00;
  // input counts and special function bit positions
  localparam int NUM_INPUTS = 16;
  localparam int NUM_ROUTES = 36;
  localparam int SF_NEG_LIMIT = 0;
  localparam int SF_POS_LIMIT = 1;
  localparam int SF_HOME = 2;
  // inputs 1 and 2 act as clock and direction in that drive mode
  localparam logic [15:0] CLKDIR_MASK = 16'h0003;
  // routing source codes
  localparam logic [6:0] SRC_ZERO = 7'h00;
  localparam logic [6:0] SRC_ENC_FIRST = 7'h44;
  localparam logic [6:0] SRC_ENC_LAST = 7'h47;
  localparam int SRC_INVERT_BIT = 7;
  // capture trigger selection
  typedef enum logic [1:0] {CAP_OFF, CAP_RISE, CAP_FALL, CAP_BOTH} dicc_capmode_t;
endpackage : dicc_pkg

// >>> inc/dicc_cap_if.sv
// link between the conditioning top and the capture unit
`timescale 1ns/100ps
interface dicc_cap_if;
  logic level; // raw sample of input 1, before override and polarity
  logic wrCtrl; // write strobes per capture entry
  logic wrCount;
  logic wrUser;
  logic wrSensor;
  logic [31:0] wrData; // write data for the strobes
  logic [31:0] userPos; // live position in user units
  logic [31:0] sensorPos; // live unscaled sensor position
  logic [31:0] ctrl; // stored trigger selection
  logic [31:0] count; // captures since start
  logic [31:0] capUser; // captured user position
  logic [31:0] capSensor; // captured sensor position
  logic capHit; // one-cycle capture pulse
  modport top (output level, wrCtrl, wrCount, wrUser, wrSensor, wrData, userPos,
    sensorPos, input ctrl, count, capUser, capSensor, capHit);
  modport cap (input level, wrCtrl, wrCount, wrUser, wrSensor, wrData, userPos,
    sensorPos, output ctrl, count, capUser, capSensor, capHit);
endinterface : dicc_cap_if

// >>> verilog/dicc_capture.sv
// position capture on edges of digital input 1
`timescale 1ns/100ps
module dicc_capture
  import dicc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  dicc_cap_if.cap capIf
);
  logic levelPrev_q; // previous sample of input 1
  logic seen_q; // sampled input holds a real level
  logic primed_q; // a previous sample exists
  logic [31:0] ctrl_q; // trigger selection
  logic [31:0] count_q; // capture counter
  logic [31:0] capUser_q; // captured user position
  logic [31:0] capSensor_q; // captured sensor position
  logic hit_q; // capture pulse
  dicc_capmode_t mode; // decoded trigger
  logic rise; // rising edge seen
  logic fall; // falling edge seen
  logic hit; // qualifying edge this cycle
  logic restart; // control written with 1, 2 or 3

  // decode trigger, values above 3 leave capture off
  // trigger select decode
  always_comb begin
    mode = (ctrl_q[31:2] == 30'h0) ? dicc_capmode_t'(ctrl_q[1:0]) : CAP_OFF;
  end

  assign rise = primed_q & capIf.level & ~levelPrev_q;
  assign fall = primed_q & ~capIf.level & levelPrev_q;

  // pick the edge the trigger asks for
  // capture on input 1 edge
  always_comb begin
    unique case (mode)
      CAP_OFF: hit = 1'b0;
      CAP_RISE: hit = rise;
      CAP_FALL: hit = fall;
      CAP_BOTH: hit = rise | fall;
    endcase
  end

  assign restart = capIf.wrCtrl && capIf.wrData[31:2] == 30'h0 && capIf.wrData[1:0] != 2'h0;

  // sample history, primed once the previous sample is a real one
  // avoids a false edge when input 1 idles high after reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      levelPrev_q <= 1'b0;
      seen_q <= 1'b0;
      primed_q <= 1'b0;
    end else begin
      levelPrev_q <= capIf.level;
      seen_q <= 1'b1;
      primed_q <= seen_q;
    end
  end

  // trigger selection register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) ctrl_q <= WORD_RESET;
    else if (capIf.wrCtrl) ctrl_q <= capIf.wrData;
  end

  // counter, a capture in the same cycle as a clear counts from zero, leaving 1
  // count captures, clear on restart
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) count_q <= WORD_RESET;
    else if (hit) count_q <= restart ? 32'h00000001 : count_q + 32'h00000001;
    else if (restart) count_q <= WORD_RESET;
    else if (capIf.wrCount) count_q <= capIf.wrData;
  end

  // captured positions, a capture beats a software write
  // store user position
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      capUser_q <= WORD_RESET;
      capSensor_q <= WORD_RESET;
      hit_q <= 1'b0;
    end else begin
      hit_q <= hit;
      if (hit) capUser_q <= capIf.userPos;
      else if (capIf.wrUser) capUser_q <= capIf.wrData;
      if (hit) capSensor_q <= capIf.sensorPos;
      else if (capIf.wrSensor) capSensor_q <= capIf.wrData;
    end
  end

  assign capIf.ctrl = ctrl_q;
  assign capIf.count = count_q;
  assign capIf.capUser = capUser_q;
  assign capIf.capSensor = capSensor_q;
  assign capIf.capHit = hit_q;
endmodule : dicc_capture

// >>> tb/dicc_top_assertions.sv
// port assertions for the input conditioning block
`timescale 1ns/100ps
module dicc_top_assertions
  import dicc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [15:0] physIn,
  input wire logic clkDirMode,
  input wire logic [15:0] objIndex,
  input wire logic [7:0] objSub,
  input wire logic objWrite,
  input wire logic objRead,
  input wire logic [31:0] objWrData,
  input wire logic objRdValid,
  input wire logic objAccessErr,
  input wire logic [31:0] inputStatus,
  input wire logic negLimitActive,
  input wire logic posLimitActive,
  input wire logic [31:0] thresholdSel,
  input wire logic [31:0] diffSel,
  input wire logic captureEvent
);
  logic [15:0] pol_q; // polarity copy
  logic [15:0] ovOn_q; // override enable copy
  logic [15:0] ovLvl_q; // override level copy
  logic [2:0] sp_q; // special enable copy
  logic route_q; // routing enable copy
  logic [31:0] thr_q; // threshold copy
  logic [31:0] diff_q; // diff select copy
  logic [1:0] capMode_q; // capture mode copy
  logic wrIn; // write to input control
  assign wrIn = objWrite && (objIndex == IDX_INPUT_CTRL);
  // mirror of the input control words
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pol_q <= 16'h0000;
      ovOn_q <= 16'h0000;
      ovLvl_q <= 16'h0000;
      sp_q <= 3'h0;
      route_q <= 1'b0;
      thr_q <= 32'h00000000;
      diff_q <= 32'h00000000;
    end else if (wrIn) begin
      case (objSub)
        SUB_SPECIAL_ON: sp_q <= objWrData[2:0];
        SUB_POLARITY: pol_q <= objWrData[15:0];
        SUB_OVERRIDE_ON: ovOn_q <= objWrData[15:0];
        SUB_OVERRIDE_LVL: ovLvl_q <= objWrData[15:0];
        SUB_THRESHOLD: thr_q <= objWrData;
        SUB_DIFF: diff_q <= objWrData;
        SUB_ROUTING_ON: route_q <= objWrData[0];
        default: ;
      endcase
    end
  end
  // mirror of the capture mode, large values mean off
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      capMode_q <= 2'h0;
    end else if (objWrite && objIndex == IDX_CAPTURE && objSub == SUB_CAP_CTRL) begin
      capMode_q <= (objWrData > 32'h3) ? 2'h0 : objWrData[1:0];
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // no config change and routing off in this cycle
  sequence s_quiet;
    !objWrite && !route_q && $stable(clkDirMode);
  endsequence
  property p_read;
    objRead |=> objRdValid || objAccessErr;
  endproperty
  property p_entry_ro;
    wrIn && objSub == SUB_ENTRIES |=> objAccessErr;
  endproperty
  property p_neg;
    negLimitActive |-> sp_q[0] || $past(sp_q[0]);
  endproperty
  property p_pos;
    posLimitActive |-> sp_q[1] || $past(sp_q[1]);
  endproperty
  property p_status;
    s_quiet [*3] |-> inputStatus == {16'h0000, (($past(physIn, 2) & ~ovOn_q)
      | (ovLvl_q & ovOn_q)) ^ (pol_q & ~(clkDirMode ? CLKDIR_MASK : 16'h0000))};
  endproperty
  property p_thr;
    $changed(thresholdSel) |-> thresholdSel == thr_q;
  endproperty
  property p_diff;
    $changed(diffSel) |-> diffSel == diff_q;
  endproperty
  property p_rise;
    capMode_q[0] && $rose(physIn[0]) |-> ##[2:3] captureEvent;
  endproperty
  property p_fall;
    capMode_q[1] && $fell(physIn[0]) |-> ##[2:3] captureEvent;
  endproperty
  property p_off;
    captureEvent |-> $past(capMode_q) != 2'h0;
  endproperty
  a_read: assert property (p_read) else $error("read not answered");
  a_entry_ro: assert property (p_entry_ro) else $error("entry count written");
  a_neg: assert property (p_neg) else $error("neg limit while off");
  a_pos: assert property (p_pos) else $error("pos limit while off");
  a_status: assert property (p_status) else $error("status mismatch");
  a_thr: assert property (p_thr) else $error("threshold mismatch");
  a_diff: assert property (p_diff) else $error("diff select mismatch");
  a_rise: assert property (p_rise) else $error("rise not captured");
  a_fall: assert property (p_fall) else $error("fall not captured");
  a_off: assert property (p_off) else $error("capture while off");
endmodule : dicc_top_assertions
bind dicc_top dicc_top_assertions i_chk (.*);

// >>> tb/dicc_switch_model.sv
// switches and encoder in front of the input block
`timescale 1ns/100ps
module dicc_switch_model #(
  parameter int ENC_RES = 4 // sensor counts per user unit
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [15:0] swLvl, // commanded contact levels
  input wire logic step, // move one unit per clock
  output logic [15:0] physIn,
  output logic encA,
  output logic encB,
  output logic encIndex,
  output logic usbPower,
  output logic [31:0] userPos,
  output logic [31:0] sensorPos
);
  logic [31:0] pos_q; // shaft position
  // position moves only while commanded
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pos_q <= 32'h00000000;
    end else if (step) begin
      pos_q <= pos_q + 32'h00000001;
    end
  end
  // contacts follow the command
  assign physIn = swLvl;
  // quadrature and index from position
  assign encA = pos_q[1];
  assign encB = pos_q[1] ^ pos_q[0];
  assign encIndex = (pos_q[7:0] == 8'h00);
  assign usbPower = 1'b1;
  assign userPos = pos_q;
  assign sensorPos = pos_q * 32'(ENC_RES);
endmodule : dicc_switch_model

// >>> tb/dicc_top_test.sv
// self-checking bench for the input conditioning block
`timescale 1ns/100ps
module dicc_top_test
  import dicc_pkg::*;
;
  localparam int ENC_RES = 4; // sensor counts per unit
  logic clk, rst_b, clkDirMode, step, objWrite, objRead, rdErr, rdOk;
  logic encA, encB, encIndex, usbPower, objRdValid, objAccessErr;
  logic negLimitActive, posLimitActive, homeActive, captureEvent;
  logic [15:0] physIn, swLvl, objIndex;
  logic [7:0] objSub;
  logic [31:0] objWrData, objRdData, inputStatus, thresholdSel, diffSel;
  logic [31:0] userPos, sensorPos, rdData;
  int errors, samplesChecked, cycles, capSeen;
  dicc_top i_dut (.clk(clk), .rst_b(rst_b), .physIn(physIn), .encA(encA),
    .encB(encB), .encIndex(encIndex), .usbPower(usbPower), .clkDirMode(clkDirMode),
    .actualUserPos(userPos), .sensorRawPos(sensorPos), .objIndex(objIndex),
    .objSub(objSub), .objWrite(objWrite), .objRead(objRead), .objWrData(objWrData),
    .objRdData(objRdData), .objRdValid(objRdValid), .objAccessErr(objAccessErr),
    .inputStatus(inputStatus), .negLimitActive(negLimitActive),
    .posLimitActive(posLimitActive), .homeActive(homeActive),
    .thresholdSel(thresholdSel), .diffSel(diffSel), .captureEvent(captureEvent));
  dicc_switch_model #(.ENC_RES(ENC_RES)) i_model (.clk(clk), .rst_b(rst_b),
    .swLvl(swLvl), .step(step), .physIn(physIn), .encA(encA), .encB(encB),
    .encIndex(encIndex), .usbPower(usbPower), .userPos(userPos), .sensorPos(sensorPos));
  // clock and hang guard
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      end_sim();
    end
  end
  // count capture pulses where settled
  always @(negedge clk) if (captureEvent === 1'b1) capSeen++;
  task automatic end_sim;
    $display("errors %0d checks %0d", errors, samplesChecked);
    if (errors == 0 && samplesChecked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samplesChecked++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one-cycle write strobe, error sampled after
  task automatic wr(input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] d);
    @(negedge clk);
    objIndex = ix;
    objSub = sb;
    objWrData = d;
    objWrite = 1'b1;
    @(negedge clk);
    objWrite = 1'b0;
    rdErr = objAccessErr;
  endtask : wr
  // one-cycle read strobe, answer in next cycle
  task automatic rd(input logic [15:0] ix, input logic [7:0] sb);
    @(negedge clk);
    objIndex = ix;
    objSub = sb;
    objRead = 1'b1;
    @(negedge clk);
    objRead = 1'b0;
    rdData = objRdData;
    rdErr = objAccessErr;
    rdOk = objRdValid;
  endtask : rd
  task automatic rdchk(input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] e);
    rd(ix, sb);
    chk("answer", 32'h1, {30'h0, rdErr, rdOk});
    chk("readback", e, rdData);
  endtask : rdchk
  task automatic t_defaults;
    rdchk(IDX_INPUT_CTRL, SUB_ENTRIES, {24'h0, INPUT_CTRL_ENTRIES});
    rdchk(IDX_CAPTURE, SUB_ENTRIES, {24'h0, CAPTURE_ENTRIES});
    for (int s = 1; s <= 8; s++) rdchk(IDX_INPUT_CTRL, 8'(s), WORD_RESET);
    for (int s = 1; s <= 4; s++) rdchk(IDX_CAPTURE, 8'(s), WORD_RESET);
    wr(IDX_INPUT_CTRL, SUB_ENTRIES, 32'h00000009);
    chk("ro write", 32'h1, {31'h0, rdErr});
    wr(16'h3245, 8'h01, 32'h00000001);
    chk("unmapped", 32'h1, {31'h0, rdErr});
    rdchk(IDX_INPUT_CTRL, SUB_ENTRIES, {24'h0, INPUT_CTRL_ENTRIES});
  endtask : t_defaults
  task automatic t_special;
    swLvl = 16'h0007;
    wr(IDX_INPUT_CTRL, SUB_SPECIAL_ON, 32'hffff0007);
    repeat (3) @(negedge clk);
    chk("switches", 32'h7, {29'h0, homeActive, posLimitActive, negLimitActive});
    wr(IDX_INPUT_CTRL, SUB_SPECIAL_ON, 32'h00000002);
    repeat (3) @(negedge clk);
    chk("switches", 32'h2, {29'h0, homeActive, posLimitActive, negLimitActive});
    wr(IDX_INPUT_CTRL, SUB_SPECIAL_ON, 32'hffff0000);
    repeat (3) @(negedge clk);
    chk("switches", 32'h0, {29'h0, homeActive, posLimitActive, negLimitActive});
  endtask : t_special
  task automatic t_routing;
    logic [7:0] src [4] = '{8'h81, 8'h80, 8'h44, 8'h01}; // sources of bits 0..3
    swLvl = 16'h0001;
    for (int i = 0; i < 4; i++) wr(IDX_ROUTING, 8'(i + 1), {24'h0, src[i]});
    rdchk(IDX_ROUTING, 8'h01, 32'h00000081);
    wr(IDX_INPUT_CTRL, SUB_ROUTING_ON, 32'h00000001);
    repeat (3) @(negedge clk);
    // encoder A is high at position 10
    chk("routed", 32'h0000000e, inputStatus);
    wr(IDX_INPUT_CTRL, SUB_ROUTING_ON, 32'h00000000);
    repeat (3) @(negedge clk);
    chk("unrouted", 32'h00000001, inputStatus);
  endtask : t_routing
  task automatic t_polarity;
    swLvl = 16'ha5a5;
    wr(IDX_INPUT_CTRL, SUB_POLARITY, 32'h0000ffff);
    repeat (3) @(negedge clk);
    chk("inverted", 32'h00005a5a, inputStatus);
    clkDirMode = 1'b1;
    repeat (3) @(negedge clk);
    chk("clkdir", 32'h00005a59, inputStatus);
    wr(IDX_INPUT_CTRL, SUB_OVERRIDE_ON, 32'h000000f0);
    wr(IDX_INPUT_CTRL, SUB_OVERRIDE_LVL, 32'h00000030);
    repeat (3) @(negedge clk);
    chk("forced", 32'h00005ac9, inputStatus);
    rdchk(IDX_INPUT_CTRL, SUB_UNMODIFIED, 32'h0000a5a5);
    clkDirMode = 1'b0;
  endtask : t_polarity
  task automatic t_threshold;
    wr(IDX_INPUT_CTRL, SUB_THRESHOLD, 32'h00000005);
    wr(IDX_INPUT_CTRL, SUB_DIFF, 32'h00000001);
    @(negedge clk);
    chk("threshold", 32'h00000005, thresholdSel);
    chk("diff", 32'h00000001, diffSel);
  endtask : t_threshold
  task automatic t_capture;
    int n [4] = '{1, 1, 2, 0}; // pulses for modes 1,2,3,0
    swLvl = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      wr(IDX_CAPTURE, SUB_CAP_CTRL, 32'((i + 1) % 4));
      capSeen = 0;
      swLvl[0] = 1'b1;
      repeat (6) @(negedge clk);
      swLvl[0] = 1'b0;
      repeat (6) @(negedge clk);
      chk("events", 32'(n[i]), 32'(capSeen));
      rdchk(IDX_CAPTURE, SUB_CAP_COUNT, (i == 3) ? 32'h2 : 32'(n[i]));
    end
    // control above 3 leaves capture off and the count alone
    wr(IDX_CAPTURE, SUB_CAP_CTRL, 32'h00000007);
    capSeen = 0;
    swLvl[0] = 1'b1;
    repeat (4) @(negedge clk);
    chk("events", 32'h0, 32'(capSeen));
    rdchk(IDX_CAPTURE, SUB_CAP_COUNT, 32'h2);
    rdchk(IDX_CAPTURE, SUB_CAP_USER, 32'd10);
    rdchk(IDX_CAPTURE, SUB_CAP_SENSOR, 32'(10 * ENC_RES));
  endtask : t_capture
  // reset, move encoder to 10, run scenarios
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    swLvl = 16'h0000;
    step = 1'b0;
    clkDirMode = 1'b0;
    objIndex = 16'h0000;
    objSub = 8'h00;
    objWrite = 1'b0;
    objRead = 1'b0;
    objWrData = 32'h00000000;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    step = 1'b1;
    repeat (10) @(negedge clk);
    step = 1'b0;
    t_defaults();
    t_special();
    t_routing();
    t_polarity();
    t_threshold();
    t_capture();
    end_sim();
  end
endmodule : dicc_top_test
